// ==== logic/sram_test_port.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - standard sixteen-state controller, reset at power-up, no separate test reset
// - decode 000 extest, 001 id, 010 hiz sample, 100 sample, 111 bypass
// - tdo from boundary, id or bypass register per instruction
// - extest floats data outputs and samples all inputs
// - sample captures pads while data outputs keep driving
// - id selected: tdi enters top id bit, shifts toward tdo
// - bypass bit cleared on capture, keeps last tdi after shifting
// - id bit 0 is one, bits 11..1 manufacturer, upper bits configuration
// - config fields: density, width, dll, rate, burst, io style
// - memory contents never leave through the test port
// - floating tms or tdi behaves as logic one
module sram_test_port #(
  // maker code value is arbitrary
  parameter logic [10:0] mfr_code = 11'h2A5,
  parameter logic is_x36 = 1'h1,
  parameter logic has_dll = 1'h1,
  parameter logic quad_rate = 1'h1,
  parameter logic burst_of_4 = 1'h1,
  parameter logic separate_io = 1'h1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tck,
  input wire tap_pkg::jtag_in_t link_in,
  output tap_pkg::jtag_out_t link_out,
  input wire logic [tap_pkg::boundary_width-1:0] pad_state,
  output logic dq_hiz
);

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic tap_pkg::tap_state_t tap_next(tap_pkg::tap_state_t s, logic tms);
    tap_pkg::tap_state_t n;
    n = tap_pkg::st_test_logic_reset;
    case (s)
      tap_pkg::st_test_logic_reset:
        n = tms ? tap_pkg::st_test_logic_reset : tap_pkg::st_run_test_idle;
      tap_pkg::st_run_test_idle:
        n = tms ? tap_pkg::st_select_dr : tap_pkg::st_run_test_idle;
      tap_pkg::st_select_dr:
        n = tms ? tap_pkg::st_select_ir : tap_pkg::st_capture_dr;
      tap_pkg::st_capture_dr:
        n = tms ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_shift_dr:
        n = tms ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_exit1_dr:
        n = tms ? tap_pkg::st_update_dr : tap_pkg::st_pause_dr;
      tap_pkg::st_pause_dr:
        n = tms ? tap_pkg::st_exit2_dr : tap_pkg::st_pause_dr;
      tap_pkg::st_exit2_dr:
        n = tms ? tap_pkg::st_update_dr : tap_pkg::st_shift_dr;
      tap_pkg::st_update_dr:
        n = tms ? tap_pkg::st_select_dr : tap_pkg::st_run_test_idle;
      tap_pkg::st_select_ir:
        n = tms ? tap_pkg::st_test_logic_reset : tap_pkg::st_capture_ir;
      tap_pkg::st_capture_ir:
        n = tms ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_shift_ir:
        n = tms ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_exit1_ir:
        n = tms ? tap_pkg::st_update_ir : tap_pkg::st_pause_ir;
      tap_pkg::st_pause_ir:
        n = tms ? tap_pkg::st_exit2_ir : tap_pkg::st_pause_ir;
      tap_pkg::st_exit2_ir:
        n = tms ? tap_pkg::st_update_ir : tap_pkg::st_shift_ir;
      tap_pkg::st_update_ir:
        n = tms ? tap_pkg::st_select_dr : tap_pkg::st_run_test_idle;
      default:
        n = tap_pkg::st_test_logic_reset;
    endcase
    return n;
  endfunction

  // instructions that use the boundary chain
  function automatic logic uses_boundary(tap_pkg::tap_op_t op);
    return (op == tap_pkg::op_extest) || (op == tap_pkg::op_sample_hiz) || (op == tap_pkg::op_sample);
  endfunction

  // only extest and hiz sample float the data outputs
  function automatic logic floats_outputs(tap_pkg::tap_op_t op);
    return (op == tap_pkg::op_extest) || (op == tap_pkg::op_sample_hiz);
  endfunction

  function automatic logic [tap_pkg::id_width-1:0] build_id();
    logic [tap_pkg::id_width-1:0] w;
    w = '0;
    w[tap_pkg::id_start_pos] = tap_pkg::id_start_bit;
    w[tap_pkg::id_mfr_lsb +: tap_pkg::mfr_width] = mfr_code;
    w[tap_pkg::id_density_lsb +: 3] = tap_pkg::density_18m;
    w[tap_pkg::id_width_lsb +: 2] = is_x36 ? tap_pkg::width_x36 : tap_pkg::width_x18;
    w[tap_pkg::id_t_pos] = has_dll;
    w[tap_pkg::id_q_pos] = quad_rate;
    w[tap_pkg::id_b_pos] = burst_of_4;
    w[tap_pkg::id_s_pos] = separate_io;
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // controller and instruction path, tck rising edge

  tap_pkg::tap_regs_t cur;
  tap_pkg::tap_regs_t next_cur;
  tap_pkg::jtag_out_t out_cur;
  tap_pkg::jtag_out_t next_out;
  logic [tap_pkg::boundary_width-1:0] pads_synced;
  logic [tap_pkg::boundary_width-1:0] boundary_capture;
  logic in_capture_dr;
  logic in_shift_dr;
  logic sel_boundary;
  logic sel_id;
  logic sel_bypass;
  logic boundary_out;
  logic id_out;
  logic bypass_out;
  logic tms;
  logic tdi;

  // the pad ring pulls both pins up, so a floating pin arrives as one
  assign tms = link_in.tms;
  assign tdi = link_in.tdi;

  always_comb
  begin
    next_cur = cur;
    // tms decides the next state on the rising edge
    next_cur.state = tap_next(cur.state, tms);
    case (cur.state)
      tap_pkg::st_test_logic_reset:
      begin
        next_cur.ir = tap_pkg::op_idcode;
      end
      tap_pkg::st_capture_ir:
      begin
        next_cur.ir_shift = tap_pkg::ir_capture_value;
      end
      tap_pkg::st_shift_ir:
      begin
        next_cur.ir_shift = {tdi, cur.ir_shift[2:1]};
      end
      tap_pkg::st_update_ir:
      begin
        // reserved codes load but route like bypass
        next_cur.ir = tap_pkg::tap_op_t'(cur.ir_shift);
      end
      default:
      begin
        next_cur.ir = cur.ir;
      end
    endcase
    next_cur.hiz_req = floats_outputs(next_cur.ir);
  end

  // power-up reset puts the controller in test logic reset
  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur.state <= tap_pkg::st_test_logic_reset;
      cur.ir_shift <= tap_pkg::ir_capture_value;
      cur.ir <= tap_pkg::op_idcode;
      cur.hiz_req <= 1'h0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data registers

  assign in_capture_dr = (cur.state == tap_pkg::st_capture_dr);
  assign in_shift_dr = (cur.state == tap_pkg::st_shift_dr);
  assign sel_boundary = uses_boundary(cur.ir);
  assign sel_id = (cur.ir == tap_pkg::op_idcode);
  assign sel_bypass = !sel_boundary && !sel_id;

  // pads are asynchronous to tck; the chain sees them two tck edges late
  tap_sync #(
    .width(tap_pkg::boundary_width)
  ) pad_sync (
    .clk(tck),
    .rst_b(rst_b),
    .d(pad_state),
    .q(pads_synced)
  );

  // internal cell replaces position 48; no-connect pads pass as seen
  always_comb
  begin
    boundary_capture = pads_synced;
    boundary_capture[tap_pkg::internal_cell_index] = tap_pkg::internal_cell_value;
  end

  // capture happens for every boundary instruction, floating or not
  // capture only; no update stage, so nothing from the chain is driven
  scan_register #(
    .width(tap_pkg::boundary_width)
  ) boundary_chain (
    .tck(tck),
    .rst_b(rst_b),
    .capture(in_capture_dr && sel_boundary),
    .shift(in_shift_dr && sel_boundary),
    .capture_value(boundary_capture),
    .tdi(tdi),
    .serial_out(boundary_out)
  );

  // tdi enters the top of the id word and walks toward tdo
  scan_register #(
    .width(tap_pkg::id_width)
  ) id_chain (
    .tck(tck),
    .rst_b(rst_b),
    .capture(in_capture_dr && sel_id),
    .shift(in_shift_dr && sel_id),
    .capture_value(build_id()),
    .tdi(tdi),
    .serial_out(id_out)
  );

  // cleared on capture, holds the last tdi bit after shifting
  scan_register #(
    .width(1)
  ) bypass_chain (
    .tck(tck),
    .rst_b(rst_b),
    .capture(in_capture_dr && sel_bypass),
    .shift(in_shift_dr && sel_bypass),
    .capture_value(tap_pkg::bypass_capture_value),
    .tdi(tdi),
    .serial_out(bypass_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // tdo, tck falling edge

  always_comb
  begin
    next_out.tdo = 1'h0;
    next_out.tdo_oe = 1'h0;
    if (cur.state == tap_pkg::st_shift_ir)
    begin
      next_out.tdo = cur.ir_shift[0];
      next_out.tdo_oe = 1'h1;
    end
    else if (in_shift_dr)
    begin
      next_out.tdo_oe = 1'h1;
      if (sel_boundary)
      begin
        next_out.tdo = boundary_out;
      end
      else if (sel_id)
      begin
        next_out.tdo = id_out;
      end
      else
      begin
        next_out.tdo = bypass_out;
      end
    end
  end

  // tdo moves on the falling edge, half a period after the shift
  always_ff @(negedge tck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_cur <= '0;
    end
    else
    begin
      out_cur <= next_out;
    end
  end

  assign link_out = out_cur;

  ////////////////////////////////////////////////////////////////////////////
  // data output float request into the sram clock domain

  // extest and hiz sample float the data outputs
  // with tck held low the request stays at its reset value
  tap_sync #(
    .width(1)
  ) hiz_sync (
    .clk(clock),
    .rst_b(rst_b),
    .d(cur.hiz_req),
    .q(dq_hiz)
  );

endmodule

// ==== logic/tap_pkg.sv ====
package tap_pkg;

  localparam int unsigned ir_width = 3;
  localparam int unsigned id_width = 32;
  localparam int unsigned boundary_width = 107;
  localparam int unsigned mfr_width = 11;

  // one-hot codes of the sixteen controller states
  typedef enum logic [15:0] {
    st_test_logic_reset = 16'h0001,
    st_run_test_idle = 16'h0002,
    st_select_dr = 16'h0004,
    st_capture_dr = 16'h0008,
    st_shift_dr = 16'h0010,
    st_exit1_dr = 16'h0020,
    st_pause_dr = 16'h0040,
    st_exit2_dr = 16'h0080,
    st_update_dr = 16'h0100,
    st_select_ir = 16'h0200,
    st_capture_ir = 16'h0400,
    st_shift_ir = 16'h0800,
    st_exit1_ir = 16'h1000,
    st_pause_ir = 16'h2000,
    st_exit2_ir = 16'h4000,
    st_update_ir = 16'h8000
  } tap_state_t;

  typedef enum logic [2:0] {
    op_extest = 3'h0,
    op_idcode = 3'h1,
    op_sample_hiz = 3'h2,
    op_reserved_3 = 3'h3,
    op_sample = 3'h4,
    op_reserved_5 = 3'h5,
    op_reserved_6 = 3'h6,
    op_bypass = 3'h7
  } tap_op_t;

  // fixed low bits loaded into the instruction shifter on capture
  localparam logic [2:0] ir_capture_value = 3'h1;
  localparam logic bypass_capture_value = 1'h0;

  // identification word layout
  localparam int unsigned id_start_pos = 0;
  localparam int unsigned id_mfr_lsb = 1;
  localparam int unsigned id_s_pos = 13;
  localparam int unsigned id_b_pos = 15;
  localparam int unsigned id_q_pos = 17;
  localparam int unsigned id_t_pos = 19;
  localparam int unsigned id_width_lsb = 21;
  localparam int unsigned id_density_lsb = 24;
  localparam logic id_start_bit = 1'h1;
  localparam logic [2:0] density_18m = 3'h1;
  localparam logic [1:0] width_x36 = 2'h3;
  localparam logic [1:0] width_x18 = 2'h2;

  // chain position 48 (index 47) is an internal cell, not a pad
  localparam int unsigned internal_cell_index = 47;
  localparam logic internal_cell_value = 1'h0;

  typedef struct packed {
    logic tms;
    logic tdi;
  } jtag_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } jtag_out_t;

  typedef struct packed {
    tap_state_t state;
    logic [2:0] ir_shift;
    tap_op_t ir;
    logic hiz_req;
  } tap_regs_t;

endpackage

// ==== logic/tap_sync.sv ====
`timescale 1ns/1ps
module tap_sync #(
  parameter int unsigned width = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);

  typedef struct packed {
    logic [width-1:0] first;
    logic [width-1:0] second;
  } sync_regs_t;

  sync_regs_t cur;
  sync_regs_t next_cur;

  // only the second stage is visible outside
  always_comb
  begin
    next_cur.first = d;
    next_cur.second = cur.first;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign q = cur.second;

endmodule

// ==== logic/scan_register.sv ====
`timescale 1ns/1ps
module scan_register #(
  parameter int unsigned width = 32
) (
  input wire logic tck,
  input wire logic rst_b,
  input wire logic capture,
  input wire logic shift,
  input wire logic [width-1:0] capture_value,
  input wire logic tdi,
  output logic serial_out
);

  typedef struct packed {
    logic [width-1:0] bits;
  } scan_regs_t;

  scan_regs_t cur;
  scan_regs_t next_cur;
  logic [width:0] shifted;

  // tdi enters at the top bit, bit 0 leaves toward tdo
  always_comb
  begin
    shifted = {tdi, cur.bits};
    next_cur = cur;
    if (capture)
    begin
      next_cur.bits = capture_value;
    end
    else if (shift)
    begin
      next_cur.bits = shifted[width:1];
    end
  end

  always_ff @(posedge tck or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign serial_out = cur.bits[0];

endmodule

// ==== dv/jtag_tester.sv ====
`timescale 1ns/1ps
module jtag_tester (
  input wire logic start,
  input wire logic [7:0] len,
  input wire logic [159:0] tms_v,
  input wire logic [159:0] tdi_v,
  input wire tap_pkg::jtag_out_t link_out,
  output logic tck,
  output tap_pkg::jtag_in_t link_in,
  output logic [159:0] tdo_v,
  output logic [159:0] oe_v,
  output logic done
);
  initial
  begin
    tck = 1'h0;
    link_in = 2'h3;
    done = 1'h0;
    tdo_v = '0;
    oe_v = '0;
    forever
    begin
      wait (start);
      for (int i = 0; i < len; i++)
      begin
        // drive after fall, sample tdo on rise
        link_in = {tms_v[i], tdi_v[i]};
        #6 tck = 1'h1;
        tdo_v[i] = link_out.tdo;
        oe_v[i] = link_out.tdo_oe;
        #6 tck = 1'h0;
      end
      link_in = 2'h3;
      done = 1'h1;
      wait (!start);
      done = 1'h0;
    end
  end
endmodule

// ==== dv/tap_monitor.sv ====
`timescale 1ns/1ps
module tap_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tck,
  input wire tap_pkg::jtag_in_t link_in,
  input wire tap_pkg::jtag_out_t link_out,
  input wire logic [tap_pkg::boundary_width-1:0] pad_state,
  input wire logic dq_hiz
);
  default clocking cb @(posedge tck);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////
  // five ones park the controller whatever state it was in
  sequence reset_to_shift_dr;
    link_in.tms [*5] ##1 !link_in.tms ##1 link_in.tms ##1 !link_in.tms [*2];
  endsequence
  sequence idle_to_shift_ir;
    !link_in.tms ##1 link_in.tms [*2] ##1 !link_in.tms [*2];
  endsequence

  a_exit_drops_oe: assert property (link_in.tms |=> !link_out.tdo_oe)
    else $error("tdo enable after exit");
  a_shift_keeps_oe: assert property (link_out.tdo_oe && !link_in.tms |=> link_out.tdo_oe)
    else $error("tdo enable lost in shift");
  a_pause_no_oe: assert property (link_out.tdo_oe && link_in.tms ##1 !link_in.tms |=> !link_out.tdo_oe)
    else $error("tdo enable in pause");
  a_idle_tdo_low: assert property (!link_out.tdo_oe |-> !link_out.tdo)
    else $error("tdo moves outside shift");
  a_reset_enters_dr: assert property (reset_to_shift_dr |=> link_out.tdo_oe)
    else $error("no shift after reset walk");
  a_reset_gives_id: assert property (reset_to_shift_dr |=> link_out.tdo)
    else $error("id start bit missing");
  a_ir_capture_one: assert property (idle_to_shift_ir |=> !link_out.tdo_oe || link_out.tdo)
    else $error("instruction capture bit 0");
  a_ir_capture_zero: assert property (idle_to_shift_ir ##1 !link_in.tms |=> !link_out.tdo)
    else $error("instruction capture bit 1");

  c_reset_walk: cover property (reset_to_shift_dr);
  c_ir_shift: cover property (idle_to_shift_ir ##1 link_out.tdo_oe);
  // the float request lives in the sram clock domain
  c_float: cover property (@(posedge clock) $rose(dq_hiz));
  c_pad_change: cover property ($changed(pad_state));
endmodule

bind sram_test_port tap_monitor tap_monitor_i (.clock(clock), .rst_b(rst_b), .tck(tck), .link_in(link_in),
  .link_out(link_out), .pad_state(pad_state), .dq_hiz(dq_hiz));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  // maker code value is arbitrary
  localparam logic [10:0] mfr = 11'h15A;
  localparam logic [31:0] id_word = {5'h0, 3'h1, 1'h0, 2'h3, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0,
    1'h1, 1'h0, mfr, 1'h1};
  logic clock;
  logic rst_b;
  logic tck;
  tap_pkg::jtag_in_t link_in;
  tap_pkg::jtag_out_t link_out;
  logic [tap_pkg::boundary_width-1:0] pad_state;
  logic dq_hiz;
  logic start;
  logic done;
  logic [7:0] len;
  logic [159:0] tms_v;
  logic [159:0] tdi_v;
  logic [159:0] tdo_v;
  logic [159:0] oe_v;
  int s;
  int s_ir;
  int cycles;
  int n_mismatch;
  int n_compared;

  sram_test_port #(.mfr_code(mfr)) sram_test_port_i (.clock(clock), .rst_b(rst_b), .tck(tck),
    .link_in(link_in), .link_out(link_out), .pad_state(pad_state), .dq_hiz(dq_hiz));
  jtag_tester jtag_tester_i (.start(start), .len(len), .tms_v(tms_v), .tdi_v(tdi_v), .link_out(link_out),
    .tck(tck), .link_in(link_in), .tdo_v(tdo_v), .oe_v(oe_v), .done(done));

  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_mismatch++;
    end
  endtask

  function automatic logic [159:0] pick(input logic [159:0] v, input int from, input int k);
    return (v >> from) & ((160'h1 << k) - 160'h1);
  endfunction

  task automatic tick;
    @(posedge clock);
    #2;
  endtask

  task automatic put(input logic m, input logic d);
    tms_v[len] = m;
    tdi_v[len] = d;
    len++;
  endtask

  // from idle, back to idle; extra idle steps let the float request settle
  task automatic ir_load(input logic [2:0] code);
    put(1'h1, 1'h1);
    put(1'h1, 1'h1);
    put(1'h0, 1'h1);
    put(1'h0, 1'h1);
    s_ir = len;
    put(1'h0, code[0]);
    put(1'h0, code[1]);
    put(1'h1, code[2]);
    put(1'h1, 1'h1);
    repeat (3) put(1'h0, 1'h1);
  endtask

  task automatic dr_scan(input int k, input logic [159:0] pat);
    put(1'h1, 1'h1);
    put(1'h0, 1'h1);
    put(1'h0, 1'h1);
    s = len;
    for (int j = 0; j < k; j++)
      put(j == k - 1, pat[j]);
    put(1'h1, 1'h1);
    put(1'h0, 1'h1);
  endtask

  task automatic run;
    tick();
    start = 1'h1;
    for (int t = 0; t < 200 && done !== 1'h1; t++)
      tick();
    // a frame that never ends counts against the run
    if (done !== 1'h1)
      n_mismatch++;
    start = 1'h0;
    tick();
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_id;
    len = 8'h0;
    put(1'h1, 1'h1);
    put(1'h0, 1'h1);
    dr_scan(64, {96'h0, 32'hFFFF_FFFF, 32'h3C5A_96E1});
    run();
    check("id then tdi", pick(tdo_v, s, 64), {96'h0, 32'h3C5A_96E1, id_word});
    check("tdo enable", pick(oe_v, s, 65), (160'h1 << 64) - 160'h1);
  endtask

  task automatic t_bypass;
    logic [7:0] pats [4] = '{8'hB2, 8'h4D, 8'hFF, 8'h01};
    for (int i = 0; i < 4; i++)
    begin
      len = 8'h0;
      // reserved codes are never loaded by the tester
      ir_load(3'h7);
      dr_scan(8, {152'h0, pats[i]});
      run();
      check("bypass", pick(tdo_v, s, 8), {152'h0, pats[i][6:0], 1'h0});
    end
    len = 8'h0;
    repeat (5) put(1'h1, 1'h1);
    put(1'h0, 1'h1);
    dr_scan(32, '1);
    run();
    check("reset to id", pick(tdo_v, s, 32), {128'h0, id_word});
  endtask

  task automatic t_scan;
    logic [2:0] codes [3] = '{3'h0, 3'h4, 3'h2};
    logic hiz [3] = '{1'h1, 1'h0, 1'h1};
    logic [106:0] pad;
    pad = 107'h6_1E3C_A5C3_96F0_F1E2_D3C4_B5A6;
    for (int i = 0; i < 3; i++)
    begin
      pad_state = pad;
      len = 8'h0;
      ir_load(codes[i]);
      dr_scan(107, '1);
      run();
      check("ir capture", pick(tdo_v, s_ir, 3), 160'h1);
      check("chain", pick(tdo_v, s, 107), {53'h0, pad & ~(107'h1 << 47)});
      repeat (4) tick();
      check("dq float", {159'h0, dq_hiz}, {159'h0, hiz[i]});
      pad = ~pad;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  // frames take well under a hundred clocks each
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    rst_b = 1'h0;
    start = 1'h0;
    len = 8'h0;
    tms_v = '0;
    tdi_v = '0;
    pad_state = '0;
    cycles = 0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (3) @(posedge clock);
    #2 rst_b = 1'h1;
    tick();
    t_id();
    t_bypass();
    t_scan();
    close_out();
  end
endmodule
